// ---- design/rca_pkg.sv ----
// Shared constants and types for the eight-bit core datapath.
// Assumes one oscillator clock and program and data memories outside.
package rca_pkg;
  // Bus widths and memory sizes.
  localparam int PC_W = 12;
  localparam int INSTR_W = 14;
  localparam int PROG_WORDS = 4096;
  localparam int DATA_WORDS = 192;
  // Instruction cycle timing: four oscillator clocks per cycle.
  localparam int INSTR_CYCLE_NS = 200;
  localparam int OSC_FREQ_MHZ = 20;
  localparam int CLKS_PER_CYCLE = INSTR_CYCLE_NS * OSC_FREQ_MHZ / 1000;
  // Reset values.
  localparam logic [PC_W-1:0] RESET_VECTOR = 12'h000;
  localparam logic [INSTR_W-1:0] NOP_WORD = 14'h3fff;
  localparam logic [7:0] W_RST = 8'h00;
  localparam logic [7:0] STATUS_RST = 8'h00;
  localparam logic [7:0] FSR_RST = 8'h00;
  // Special function register locations in the data map.
  localparam logic [7:0] ADDR_INDF = 8'h00;
  localparam logic [7:0] ADDR_PCL = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_FSR = 8'h04;
  // Flag positions in the status register.
  localparam int ST_C = 0;
  localparam int ST_DC = 1;
  localparam int ST_Z = 2;
  // Instruction classes in bits 13:12.
  localparam logic [1:0] CLS_FILE = 2'h0;
  localparam logic [1:0] CLS_LIT = 2'h1;
  localparam logic [1:0] CLS_GOTO = 2'h2;
  localparam logic [1:0] CLS_WREG = 2'h3;
  // Quarter phases of one instruction cycle.
  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001, PH_Q2 = 4'b0010, PH_Q3 = 4'b0100, PH_Q4 = 4'b1000
  } rca_phase_t;
  // Arithmetic unit functions, also the file-class opcodes.
  typedef enum logic [2:0] {
    ALU_ADD = 3'h0, ALU_SUB = 3'h1, ALU_AND = 3'h2, ALU_IOR = 3'h3,
    ALU_XOR = 3'h4, ALU_PASS = 3'h5, ALU_RRF = 3'h6, ALU_RLF = 3'h7
  } rca_alu_op_t;
  // Literal-class opcodes.
  typedef enum logic [2:0] {
    LIT_MOVLW = 3'h0, LIT_ADDLW = 3'h1, LIT_SUBLW = 3'h2, LIT_ANDLW = 3'h3,
    LIT_IORLW = 3'h4, LIT_XORLW = 3'h5, LIT_MOVWF = 3'h6, LIT_NOP = 3'h7
  } rca_lit_op_t;
  // Arithmetic result with its carries.
  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       dc;
  } rca_alu_t;
  // Data memory request.
  typedef struct packed {
    logic       rd;
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rca_dreq_t;
endpackage

// ---- design/rca_core.sv ----
// Eight-bit core datapath: fetch, two-stage pipeline, ALU and flags.
// Assumes program memory answers o_prog_addr within four clocks and the
// data register file answers o_dreq.addr within one clock.
//
// Behaviour
// RULE_01: Separate program and data memory buses.
// RULE_02: Fetch one 14-bit word per cycle.
// RULE_03: Fetch overlaps execute; one cycle per instruction.
// RULE_04: Branches flush fetched word, taking two cycles.
// RULE_05: Address 4K program words, 192 data bytes.
// RULE_06: Special registers reachable directly and indirectly.
// RULE_07: Eight-bit add, subtract, shift, logic unit.
// RULE_08: Two-operand ops use accumulator and file/literal.
// RULE_09: Single-operand ops use accumulator or file.
// RULE_10: Accumulator has no data memory address.
// RULE_11: Update carry, digit carry, zero per instruction.
// RULE_12: Subtraction flags report borrow and nibble borrow.
// RULE_13: RC mode drives cycle output at quarter rate.
// RULE_14: Master clear low resets, high runs.
// RULE_15: Carry is inverted borrow; digit carry bit 3.
// RULE_16: Zero flag set on all-zero result.
// RULE_17: Master clear resets counter, pipeline, vector.
`timescale 1ns/1ps
`default_nettype none
module rca_core
  import rca_pkg::*;
#(
  parameter int DATA_DEPTH = DATA_WORDS
) (
  // Clock and active-low master clear.
  input  wire logic               i_sys_clk,
  input  wire logic               i_nrst,
  // Oscillator mode pin, high selects RC mode.
  input  wire logic               i_rc_mode,
  // Program memory fetch bus.
  output logic      [PC_W-1:0]    o_prog_addr,
  input  wire logic [INSTR_W-1:0] i_prog_data,
  // Data memory bus.
  output rca_dreq_t               o_dreq,
  input  wire logic [7:0]         i_data_rdata,
  // Visible core state and cycle-rate output.
  output logic      [7:0]         o_w,
  output logic      [7:0]         o_status,
  output logic                    o_cycle_rate_out
);

  // Core state registers.
  rca_phase_t         phase;       // Current quarter of the cycle.
  rca_phase_t         next_phase;  // Following quarter.
  logic [PC_W-1:0]    pc;          // Address of the word being fetched.
  logic [INSTR_W-1:0] ir;          // Word being executed.
  logic [7:0]         w;           // Working accumulator, not mapped.
  logic [7:0]         status;      // Flags register.
  logic [7:0]         fsr;         // Indirect pointer.
  logic [7:0]         operand;     // File operand read in Q2.
  rca_alu_t           alu_q;       // Result held from Q3 to Q4.
  logic [2:0]         rc_sync;     // Pin synchroniser.
  logic               rc_mode;     // Filtered oscillator mode.

  // Arithmetic unit, two's complement; sub computes a minus b.
  function automatic rca_alu_t alu(input rca_alu_op_t f,
                                   input logic [7:0] a,
                                   input logic [7:0] b,
                                   input logic cin);
    rca_alu_t   r;
    logic [8:0] s;
    logic [4:0] n;
    r = '0;
    s = '0;
    n = '0;
    case (f)
      ALU_ADD: begin
        s = {1'b0, a} + {1'b0, b};
        n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
      end
      ALU_SUB: begin
        // Adding the complement gives carry set when nothing borrows.
        s = {1'b0, a} + {1'b0, ~b} + 9'h001;
        n = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
      end
      ALU_AND: s = {1'b0, a & b};
      ALU_IOR: s = {1'b0, a | b};
      ALU_XOR: s = {1'b0, a ^ b};
      ALU_PASS: s = {1'b0, a};
      ALU_RRF: s = {a[0], cin, a[7:1]};
      default: s = {a[7], a[6:0], cin};
    endcase
    r.res = s[7:0];  // RULE_07
    r.c = s[8];  // RULE_15
    r.dc = n[4];  // RULE_12
    return r;
  endfunction

  // Maps a literal opcode onto the unit.
  function automatic rca_alu_op_t lit_fn(input logic [2:0] op);
    case (op)
      LIT_ADDLW: return ALU_ADD;
      LIT_SUBLW: return ALU_SUB;
      LIT_ANDLW: return ALU_AND;
      LIT_IORLW: return ALU_IOR;
      LIT_XORLW: return ALU_XOR;
      default: return ALU_PASS;
    endcase
  endfunction

  // Which flags an operation touches, ordered zero, digit carry, carry.
  function automatic logic [2:0] flag_mask(input rca_alu_op_t f);
    case (f)
      ALU_ADD, ALU_SUB: return 3'h7;
      ALU_RRF, ALU_RLF: return 3'h1;
      default: return 3'h4;
    endcase
  endfunction

  // Instruction fields.
  wire [1:0] cls = ir[13:12];
  wire [2:0] op = ir[11:9];
  wire       dst_f = ir[8];
  wire [7:0] fld = ir[7:0];

  // Class decode.
  wire is_file = (cls == CLS_FILE);
  wire is_lit = (cls == CLS_LIT) && (op != LIT_MOVWF) && (op != LIT_NOP);
  wire is_movwf = (cls == CLS_LIT) && (op == LIT_MOVWF);
  wire is_goto = (cls == CLS_GOTO);
  wire is_wrot = (cls == CLS_WREG) && (op[2:1] == 2'h0);

  // Indirect access goes through the pointer register.
  wire [7:0] ea = (fld == ADDR_INDF) ? fsr : fld;  // RULE_06
  wire       ea_null = (ea == ADDR_INDF);
  wire       ea_sfr = (ea == ADDR_PCL) || (ea == ADDR_STATUS) ||
                      (ea == ADDR_FSR);
  // Only real memory locations reach the external data bus.
  wire       ext = !ea_null && !ea_sfr &&
                   ({1'b0, ea} < 9'(DATA_DEPTH));  // RULE_05

  // Internal special register read value.
  wire [7:0] sfr_val = (ea == ADDR_PCL) ? pc[7:0] :  // RULE_06
                       (ea == ADDR_STATUS) ? status :
                       (ea == ADDR_FSR) ? fsr : 8'h00;

  // Operand and function selection.
  wire rca_alu_op_t fn = is_file ? rca_alu_op_t'(op) :
                         is_wrot ? (op[0] ? ALU_RLF : ALU_RRF) :
                         lit_fn(op);
  // Accumulator on b; literal, file or accumulator on a.
  wire [7:0] alu_a = is_lit ? fld :  // RULE_08
                     (is_wrot || is_movwf) ? w : operand;  // RULE_09
  wire [7:0] alu_b = w;
  wire rca_alu_t alu_now = alu(fn, alu_a, alu_b, status[ST_C]);

  // Destinations and flags.
  wire       wr_w = (is_file && !dst_f) || is_lit || is_wrot;
  wire       wr_f = (is_file && dst_f) || is_movwf;
  wire       no_flags = is_movwf || (is_lit && op == LIT_MOVLW);
  wire [2:0] mask = (is_file || is_lit || is_wrot) && !no_flags ?
                    flag_mask(fn) : 3'h0;

  // A jump or a write to the low counter byte discards the fetched word.
  wire pcl_wr = wr_f && (ea == ADDR_PCL);
  wire branch = is_goto || pcl_wr;  // RULE_04
  wire [PC_W-1:0] target = is_goto ? ir[PC_W-1:0] :
                           {pc[PC_W-1:8], alu_q.res};
  wire [PC_W-1:0] next_pc = branch ? target : pc + 12'h001;

  // Status after the optional file write, flags laid over it.
  logic [7:0] next_status;
  always_comb begin
    next_status = (wr_f && ea == ADDR_STATUS) ? alu_q.res : status;
    if (mask[0]) begin
      next_status[ST_C] = alu_q.c;  // RULE_11
    end
    if (mask[1]) begin
      next_status[ST_DC] = alu_q.dc;  // RULE_11
    end
    if (mask[2]) begin
      next_status[ST_Z] = (alu_q.res == 8'h00);  // RULE_16
    end
  end

  // Phase ring: the instruction cycle is four clocks.
  always_comb begin
    case (phase)
      PH_Q1: next_phase = PH_Q2;
      PH_Q2: next_phase = PH_Q3;
      PH_Q3: next_phase = PH_Q4;
      default: next_phase = PH_Q1;
    endcase
  end

  // Phase register and mode pin synchroniser.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      phase <= PH_Q1;
      rc_sync <= 3'h0;
      rc_mode <= 1'b0;
    end else begin
      phase <= next_phase;
      rc_sync <= {rc_sync[1:0], i_rc_mode};
      // A change counts only once the two later stages agree.
      if (rc_sync[2] == rc_sync[1]) begin
        rc_mode <= rc_sync[2];
      end
    end
  end

  // Cycle-rate output, high through Q3 and Q4 in RC mode.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cycle_rate_out <= 1'b0;
    end else begin
      o_cycle_rate_out <= rc_mode &&  // RULE_13
        (next_phase == PH_Q3 || next_phase == PH_Q4);
    end
  end

  // Data bus: address after Q1, read in Q2, write strobe in Q4.
  // The fetch bus runs on its own so both proceed in one cycle.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_dreq <= '0;
      operand <= 8'h00;
      alu_q <= '0;
    end else begin
      case (phase)
        PH_Q1: begin
          o_dreq.addr <= ea;  // RULE_01
          o_dreq.rd <= ext && is_file;
        end
        PH_Q2: begin
          operand <= ext ? i_data_rdata : sfr_val;
          o_dreq.rd <= 1'b0;
        end
        PH_Q3: begin
          alu_q <= alu_now;
          o_dreq.we <= ext && wr_f;
          o_dreq.wdata <= alu_now.res;
        end
        default: o_dreq.we <= 1'b0;
      endcase
    end
  end

  // Commit at the end of Q4 and load the next word into the pipeline.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pc <= RESET_VECTOR;  // RULE_17
      ir <= NOP_WORD;
      w <= W_RST;
      status <= STATUS_RST;
      fsr <= FSR_RST;
    end else if (phase == PH_Q4) begin
      pc <= next_pc;  // RULE_03
      ir <= branch ? NOP_WORD : i_prog_data;  // RULE_02
      status <= next_status;
      if (wr_w) begin
        w <= alu_q.res;  // RULE_10
      end
      if (wr_f && ea == ADDR_FSR) begin
        fsr <= alu_q.res;
      end
    end
  end

  // Outputs straight from registers.
  assign o_prog_addr = pc;
  assign o_w = w;
  assign o_status = status;

  // Checks, all on the core clock, quiet during master clear.
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);  // RULE_14

  property p_phase_ring;
    phase == PH_Q1 |=> phase == PH_Q2 ##1 phase == PH_Q3
      ##1 phase == PH_Q4 ##1 phase == PH_Q1;
  endproperty
  a_phase_ring: assert property (p_phase_ring)  // RULE_03
    else $error("phase ring broken");
  property p_fetch_once;
    $changed(o_prog_addr) |-> $past(phase) == PH_Q4;
  endproperty
  a_fetch_once: assert property (p_fetch_once)  // RULE_02
    else $error("fetch address moved outside Q4");
  property p_flush;
    phase == PH_Q4 && branch |=> ir == NOP_WORD && pc == $past(target);
  endproperty
  a_flush: assert property (p_flush)  // RULE_04
    else $error("branch did not discard fetched word");
  property p_seq;
    phase == PH_Q4 && !branch |=> pc == $past(pc) + 12'h001;
  endproperty
  a_seq: assert property (p_seq)  // RULE_03
    else $error("counter did not advance by one");
  property p_we_q4;
    o_dreq.we |-> phase == PH_Q4 && !ea_sfr && !ea_null;
  endproperty
  a_we_q4: assert property (p_we_q4)  // RULE_01
    else $error("write strobe outside Q4 or on a core register");
  property p_zero;
    phase == PH_Q4 && mask[2] |=>
      status[ST_Z] == ($past(alu_q.res) == 8'h00);
  endproperty
  a_zero: assert property (p_zero)  // RULE_16
    else $error("zero flag wrong");
  property p_borrow;
    phase == PH_Q4 && mask[0] && fn == ALU_SUB |=>
      status[ST_C] == ($past(alu_a) >= $past(alu_b)) &&
      status[ST_DC] == ($past(alu_a[3:0]) >= $past(alu_b[3:0]));
  endproperty
  a_borrow: assert property (p_borrow)  // RULE_15
    else $error("subtract carry is not inverted borrow");
  // The mode must hold through Q2 as well, since the pin may drop anywhere.
  property p_cycle_rate_output;
    phase == PH_Q3 && rc_mode && $past(rc_mode) |->
      o_cycle_rate_out ##1 o_cycle_rate_out ##1 !o_cycle_rate_out;
  endproperty
  a_cycle_rate_output: assert property (p_cycle_rate_output)  // RULE_13
    else $error("cycle-rate output wrong in RC mode");
  property p_w_only_alu;
    $changed(w) |-> $past(phase) == PH_Q4 && $past(wr_w);
  endproperty
  a_w_only_alu: assert property (p_w_only_alu)  // RULE_10
    else $error("accumulator changed without an ALU write");
  // Main scenarios.
  property p_cov_branch;
    phase == PH_Q4 && is_goto;
  endproperty
  c_cov_branch: cover property (p_cov_branch);
  property p_cov_borrow;
    phase == PH_Q4 && fn == ALU_SUB && mask[0] && !alu_q.c;
  endproperty
  c_cov_borrow: cover property (p_cov_borrow);
  // Indirect read through the pointer reaching the external bus.
  property p_cov_indirect;
    phase == PH_Q2 && is_file && fld == ADDR_INDF && o_dreq.rd;
  endproperty
  c_cov_indirect: cover property (p_cov_indirect);
endmodule
`default_nettype wire

// ---- verif/rca_mem_model.sv ----
// Behavioural program memory and data register file facing the core.
// Assumes the bench loads both arrays by hierarchical reference.
`timescale 1ns/1ps
`default_nettype none
module rca_mem_model
  import rca_pkg::*;
(
  // Clock.
  input  wire logic               i_sys_clk,
  // Fetch side.
  input  wire logic [PC_W-1:0]    i_prog_addr,
  output logic      [INSTR_W-1:0] o_prog_data,
  // Data side.
  input  wire rca_dreq_t          i_dreq,
  output logic      [7:0]         o_data_rdata
);
  logic [INSTR_W-1:0] prog [PROG_WORDS]; // Program words.
  logic [7:0]         dmem [DATA_WORDS]; // Data bytes.
  logic [7:0]         last_rd = 8'h00;   // Last byte handed out.

  // The fetch path is its own bus and returns the whole word.
  assign o_prog_data = prog[i_prog_addr];

  // Outside a read strobe the bus shows the inverse of the last byte, so a
  // sample taken at the wrong edge cannot pass by luck.
  assign o_data_rdata = i_dreq.rd ? dmem[i_dreq.addr] : ~last_rd;

  // Writes land on the rising edge; plain always so the bench may preload.
  always @(posedge i_sys_clk) begin
    if (i_dreq.rd) begin
      last_rd <= dmem[i_dreq.addr];
    end
    if (i_dreq.we) begin
      dmem[i_dreq.addr] <= i_dreq.wdata;
    end
  end
endmodule
`default_nettype wire

// ---- verif/risc_core_alu_datapath_test.sv ----
// Self-checking bench for the core datapath and its memory model.
// Assumes four clocks per instruction cycle, phase Q1 at release.
`timescale 1ns/1ps
`default_nettype none
module risc_core_alu_datapath_test;
  import rca_pkg::*;
  logic               i_sys_clk;   // Oscillator, 50 ns period.
  logic               i_nrst;      // Master clear, active low.
  logic               i_rc_mode;   // Oscillator mode pin.
  logic [PC_W-1:0]    prog_addr;   // Fetch address.
  logic [INSTR_W-1:0] prog_data;   // Fetched word.
  rca_dreq_t          dreq;        // Data request.
  logic [7:0]         rdata;       // Data read byte.
  logic [7:0]         w_reg;       // Accumulator.
  logic [7:0]         status;      // Flags.
  logic               cyc_out;     // Cycle-rate output.
  int                 fails;       // Mismatch count.
  int                 comparisons; // Compare count.

  rca_core dut (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .i_rc_mode(i_rc_mode), .o_prog_addr(prog_addr),
    .i_prog_data(prog_data), .o_dreq(dreq), .i_data_rdata(rdata),
    .o_w(w_reg), .o_status(status), .o_cycle_rate_out(cyc_out));
  rca_mem_model mdl (.i_sys_clk(i_sys_clk), .i_prog_addr(prog_addr),
    .o_prog_data(prog_data), .i_dreq(dreq), .o_data_rdata(rdata));

  // Free-running oscillator.
  initial begin
    i_sys_clk = 1'b0;
    forever #25 i_sys_clk = ~i_sys_clk;
  end

  // Compares with case equality so an unknown never matches.
  task automatic check(input string what, input logic [17:0] seen,
                       input logic [17:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Instruction builders for the literal and file classes.
  function automatic logic [13:0] lit(rca_lit_op_t op, logic [7:0] k);
    return {CLS_LIT, op, 1'b0, k};
  endfunction
  function automatic logic [13:0] fil(rca_alu_op_t op, logic d,
                                      logic [7:0] a);
    return {CLS_FILE, op, d, a};
  endfunction

  // Holds master clear for five clocks while both memories are cleared.
  task automatic start();
    @(posedge i_sys_clk);
    #1 i_nrst = 1'b0;
    for (int i = 0; i < PROG_WORDS; i++) mdl.prog[i] = NOP_WORD;
    for (int i = 0; i < DATA_WORDS; i++) mdl.dmem[i] = 8'h00;
    repeat (5) @(posedge i_sys_clk);
  endtask

  // Releases master clear and lets the program run a number of clocks.
  task automatic go(input int clks);
    #1 i_nrst = 1'b1;
    repeat (clks) @(posedge i_sys_clk);
    #1;
  endtask

  // Reset state, fetch stepping, and a second reset in mid-run.
  task automatic t_reset();
    int hi;
    hi = 0;
    start();
    check("fetch address in reset", prog_addr, 0);
    check("accumulator in reset", w_reg, 0);
    check("status in reset", status, 0);
    check("data request in reset", dreq, 0);
    go(4);
    check("fetch after one cycle", prog_addr, 1);
    for (int i = 0; i < 16; i++) begin
      if (cyc_out !== 1'b0) hi++;
      @(posedge i_sys_clk);
      #1;
    end
    check("fetch after five cycles", prog_addr, 5);
    check("cycle output outside RC mode", hi, 0);
    i_nrst = 1'b0;
    #1 check("fetch address on mid-run reset", prog_addr, 0);
    $display("test reset done");
  endtask

  // One literal or accumulator operation after a load, from a table of
  // start value, instruction, result and flags.
  task automatic t_alu();
    logic [37:0] tbl [9] = '{
      {8'h0f, lit(LIT_ADDLW, 8'h01), 8'h10, 8'h02},
      {8'hff, lit(LIT_ADDLW, 8'h01), 8'h00, 8'h07},
      {8'h01, lit(LIT_SUBLW, 8'h00), 8'hff, 8'h00},
      {8'h05, lit(LIT_SUBLW, 8'h05), 8'h00, 8'h07},
      {8'h10, lit(LIT_SUBLW, 8'h08), 8'hf8, 8'h02},
      {8'hf0, lit(LIT_ANDLW, 8'h0f), 8'h00, 8'h04},
      {8'hf0, lit(LIT_IORLW, 8'h0f), 8'hff, 8'h00},
      {8'haa, lit(LIT_XORLW, 8'haa), 8'h00, 8'h04},
      {8'h81, {CLS_WREG, 3'h1, 9'h000}, 8'h02, 8'h01}};
    for (int i = 0; i < 9; i++) begin
      start();
      mdl.prog[0] = lit(LIT_MOVLW, tbl[i][37:30]);
      mdl.prog[1] = tbl[i][29:16];
      mdl.prog[2] = {CLS_GOTO, 12'h002};
      go(20);
      check("alu result", w_reg, tbl[i][15:8]);
      check("alu flags", status, tbl[i][7:0]);
    end
    $display("test alu done");
  endtask

  // File operands, a store, the pointer and indirect read, and a rotate.
  task automatic t_file();
    start();
    mdl.dmem[8'h20] = 8'h33;
    mdl.dmem[8'h22] = 8'h03;
    mdl.prog[0] = lit(LIT_MOVLW, 8'h11);
    mdl.prog[1] = fil(ALU_ADD, 1'b0, 8'h20);
    mdl.prog[2] = lit(LIT_MOVWF, 8'h21);
    mdl.prog[3] = lit(LIT_MOVLW, 8'h20);
    mdl.prog[4] = lit(LIT_MOVWF, ADDR_FSR);
    mdl.prog[5] = fil(ALU_PASS, 1'b0, ADDR_INDF);
    mdl.prog[6] = fil(ALU_RRF, 1'b1, 8'h22);
    mdl.prog[7] = {CLS_GOTO, 12'h007};
    go(40);
    check("stored sum", mdl.dmem[8'h21], 8'h44);
    check("indirect read", w_reg, 8'h33);
    check("rotated file", mdl.dmem[8'h22], 8'h01);
    check("rotate flags", status, 8'h01);
    check("pointer write kept inside", mdl.dmem[4], 8'h00);
    $display("test file done");
  endtask

  // The counter's low byte as a data location: read it, then write it to
  // branch; the word fetched behind that write must never run.
  task automatic t_pcl();
    start();
    mdl.prog[0] = fil(ALU_PASS, 1'b0, ADDR_PCL);
    mdl.prog[1] = lit(LIT_MOVWF, 8'h30);
    mdl.prog[2] = lit(LIT_MOVLW, 8'h10);
    mdl.prog[3] = lit(LIT_MOVWF, ADDR_PCL);
    mdl.prog[4] = lit(LIT_MOVLW, 8'haa);
    mdl.prog[8'h10] = fil(ALU_SUB, 1'b0, 8'h30);
    mdl.prog[8'h11] = {CLS_GOTO, 12'h011};
    go(40);
    check("counter low byte read", mdl.dmem[8'h30], 8'h01);
    check("result after counter write", w_reg, 8'hf1);
    check("file subtract flags", status, 8'h02);
    check("fetch after counter write", prog_addr, 12'h011);
    $display("test pcl done");
  endtask

  // A branch to the top word: flushed word never runs, two-cycle branch,
  // and the fetch address wraps to zero.
  task automatic t_branch();
    int              bad;
    int              t0;
    int              t1;
    logic [PC_W-1:0] prev;
    bad = 0;
    t0 = 0;
    t1 = 0;
    prev = 12'h000;
    start();
    mdl.prog[0] = {CLS_GOTO, 12'hfff};
    mdl.prog[1] = lit(LIT_MOVLW, 8'haa);
    mdl.prog[12'hfff] = lit(LIT_MOVLW, 8'h55);
    go(4);
    for (int i = 0; i < 40; i++) begin
      if (w_reg === 8'haa) bad++;
      if (prog_addr === 12'hfff && prev !== 12'hfff) begin
        t0 = t1;
        t1 = i;
      end
      prev = prog_addr;
      @(posedge i_sys_clk);
      #1;
    end
    check("flushed word executed", bad, 0);
    check("branch loop clocks", t1 - t0, 3 * CLKS_PER_CYCLE);
    check("accumulator after wrap", w_reg, 8'h55);
    $display("test branch done");
  endtask

  // Cycle-rate output in RC mode: two clocks high in every four.
  task automatic t_rc();
    int   hi;
    int   rise;
    logic prev;
    hi = 0;
    rise = 0;
    i_rc_mode = 1'b1;
    repeat (8) @(posedge i_sys_clk);
    #1 prev = cyc_out;
    for (int i = 0; i < 16; i++) begin
      @(posedge i_sys_clk);
      #1;
      if (cyc_out === 1'b1) hi++;
      if (cyc_out === 1'b1 && prev === 1'b0) rise++;
      prev = cyc_out;
    end
    check("cycle output high clocks", hi, 8);
    check("cycle output rises", rise, 4);
    i_rc_mode = 1'b0;
    $display("test rc done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop();
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog: the tests need about 22 us, so reaching 200 us means a hang.
  initial begin
    #200000;
    fails++;
    report_and_stop();
  end

  // Main sequence.
  initial begin
    i_nrst = 1'b0;
    i_rc_mode = 1'b0;
    fails = 0;
    comparisons = 0;
    t_reset();
    t_alu();
    t_file();
    t_pcl();
    t_branch();
    t_rc();
    report_and_stop();
  end
endmodule
`default_nettype wire
